// file: include/aac_pkg.sv
package aac_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CHAN = 8'h04;
  localparam logic [7:0] REG_PACER = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_ISTAT = 8'h18;
  localparam logic [7:0] REG_IMASK = 8'h1c;
  // control, channel, command and status fields
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_SCAN = 2;
  localparam int CTRL_DIFF = 3;
  localparam int CTRL_GAIN_LSB = 4;
  localparam int CTRL_BIP = 6;
  localparam int CTRL_EXTCLK = 7;
  localparam int CTRL_EN = 8;
  localparam int CHAN_LO_LSB = 0;
  localparam int CHAN_HI_LSB = 8;
  localparam int CMD_SWTRIG = 0;
  localparam int CMD_FLUSH = 1;
  localparam int STAT_FULL = 16;
  localparam int STAT_EMPTY = 17;
  localparam int STAT_BUSY = 18;
  // interrupt status / mask bits
  localparam int IRQ_CONV = 0;
  localparam int IRQ_SCAN = 1;
  localparam int IRQ_HALF = 2;
  localparam int IRQ_UNDER = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CHAN_RST = 32'h0000_0000;
  localparam logic [31:0] PACER_RST = 32'h0000_0063;
  localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;
  // sizes
  localparam int SAMPLE_W = 16;
  localparam int PACER_W = 32;
  localparam int FIFO_DEPTH = 512;
  localparam int FIFO_HALF = 256;
  localparam int CH_SE = 16;
  localparam int CH_DIFF = 8;
  localparam int CH_W = 4;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int PACER_REF_HZ = 10_000_000;
  localparam int PACER_DIV = CLK_HZ / PACER_REF_HZ;
  localparam int DIV_W = 3;

  typedef enum logic [1:0] {TRIG_SW, TRIG_PACER, TRIG_EXT} aac_trig_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_START, SQ_WAIT} aac_seq_t;
endpackage : aac_pkg

// file: include/aac_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aac_fifo_if #(parameter int W = 16, parameter int CW = 10);
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [CW-1:0] count;
  logic full;
  logic empty;
  modport store (input push, pop, flush, wdata, output rdata, count, full, empty);
  modport user (output push, pop, flush, wdata, input rdata, count, full, empty);
endinterface : aac_fifo_if
`default_nettype wire

// file: design/aac_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module aac_fifo #(
  parameter int DEPTH = 512,
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  aac_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  // a push into a full store is dropped
  assign do_push = f.push & (cnt_reg != FULL_CNT);
  assign do_pop = f.pop & (cnt_reg != '0);

  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (f.flush) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end else begin
      if (do_push) wr_next = wr_reg + 1'b1;
      if (do_pop) rd_next = rd_reg + 1'b1;
      if (do_push & ~do_pop) cnt_next = cnt_reg + 1'b1;
      else if (do_pop & ~do_push) cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset; contents are unread until written
  always_ff @(posedge clk) begin
    if (do_push && !f.flush) mem[wr_reg] <= f.wdata;
  end

  assign f.rdata = mem[rd_reg];
  assign f.count = cnt_reg;
  assign f.full = (cnt_reg == FULL_CNT);
  assign f.empty = (cnt_reg == '0);
endmodule : aac_fifo
`default_nettype wire

// file: design/aac_top.sv
// Operation
// R1: results buffered 512 deep; interrupt raised when 256 samples are held.
// R2: interrupt causes: conversion done, scan done, store half full.
// R3: full flag when store cannot accept; underflow flag on read of empty store.
// R4: conversion start from software command, pacer, or external trigger.
// R5: single mode repeats one channel; scan mode steps a channel range once.
// R6: 32-bit down counter paces sampling; each expiry issues a trigger.
// R7: pacer counts either on-board 10 MHz ticks or an external clock.
// R8: host keeps the total conversion rate at or below 100 kHz.
// R9: 16 single-ended or 8 differential inputs; channel limited to that count.
// R10: each result is captured as 16 bits into one store entry.
// R11: drive front-end gain 1, 2, 4 or 8 and unipolar or bipolar range.
// R12: each read returns and removes oldest sample; empty read flags underflow.
// R13: interrupt held until host clears it; only new events raise it again.
`timescale 1ns/1ps
`default_nettype none
module aac_top
  import aac_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int HALF = FIFO_HALF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic ext_trig,
  input wire logic ext_clk,
  input wire logic adc_done,
  input wire logic [SAMPLE_W-1:0] adc_data,
  output logic adc_start,
  output logic [CH_W-1:0] adc_chan,
  output logic [1:0] adc_gain,
  output logic adc_bipolar
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [CW-1:0] HALF_CNT = CW'(HALF);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PACER_DIV - 1);

  aac_fifo_if #(.W(SAMPLE_W), .CW(CW)) fif ();

  aac_fifo #(
    .DEPTH(DEPTH),
    .W(SAMPLE_W)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .f(fif.store)
  ); // R1

  // pin synchronisers
  logic trig_s1, trig_s2, trig_s3;
  logic eclk_s1, eclk_s2, eclk_s3;
  logic done_s1, done_s2, done_s3;
  logic [SAMPLE_W-1:0] data_s1, data_s2;
  logic trig_rise, eclk_rise, done_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      eclk_s1 <= 1'b0;
      eclk_s2 <= 1'b0;
      eclk_s3 <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      trig_s1 <= ext_trig;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      eclk_s1 <= ext_clk;
      eclk_s2 <= eclk_s1;
      eclk_s3 <= eclk_s2;
      done_s1 <= adc_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      data_s1 <= adc_data;
      data_s2 <= data_s1;
    end
  end

  // third stage only feeds the edge detectors, never the first stage
  assign trig_rise = trig_s2 & ~trig_s3;
  assign eclk_rise = eclk_s2 & ~eclk_s3;
  // data is settled before done rises, so the synced copy is valid here
  assign done_rise = done_s2 & ~done_s3;

  // registers and bus
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] chan_reg, chan_next;
  logic [PACER_W-1:0] pacer_reg, pacer_next;
  logic [IRQ_W-1:0] imask_reg, imask_next;
  logic [IRQ_W-1:0] istat_reg, istat_next;
  logic [31:0] dat_reg, dat_next;
  logic ack_reg, irq_reg, irq_next;
  // ack feeds back into req, so a held strobe gets one ack per access
  logic ack_next;
  logic half_reg;
  // level history keeps the half-full cause a single event per crossing
  logic half_next;
  logic req, wr, rd, sw_trig, flush;
  logic ev_conv, ev_scan, ev_half, ev_under;
  logic [IRQ_W-1:0] events, w1c;
  logic [31:0] stat_word;
  logic busy;
  aac_trig_t trig_sel;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // one access per ack; ack drops the cycle after it is given
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  // command bits are strobes and leave no state behind
  assign sw_trig = wr & (wb_adr_i == REG_CMD) & wb_sel_i[0] & wb_dat_i[CMD_SWTRIG];
  assign flush = wr & (wb_adr_i == REG_CMD) & wb_sel_i[0] & wb_dat_i[CMD_FLUSH];
  assign trig_sel = aac_trig_t'(ctrl_reg[CTRL_TRIG_LSB +: 2]);

  // pop on read of data port; empty read only sets underflow
  assign fif.pop = rd & (wb_adr_i == REG_DATA) & ~fif.empty; // R12
  assign fif.flush = flush;
  assign ev_under = rd & (wb_adr_i == REG_DATA) & fif.empty; // R3 R12
  assign ev_half = (fif.count >= HALF_CNT) & ~half_reg; // R1 R2

  assign events = {ev_under, ev_half, ev_scan, ev_conv}; // R2
  // status bits live in lane 0, so only that lane clears them
  assign w1c = (wr && wb_adr_i == REG_ISTAT && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;

  always_comb begin
    stat_word = '0;
    stat_word[CW-1:0] = fif.count;
    stat_word[STAT_FULL] = fif.full; // R3
    stat_word[STAT_EMPTY] = fif.empty;
    stat_word[STAT_BUSY] = busy;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    chan_next = chan_reg;
    pacer_next = pacer_reg;
    imask_next = imask_reg;
    dat_next = dat_reg;
    if (wr) begin
      case (wb_adr_i)
        REG_CTRL: ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i);
        REG_CHAN: chan_next = merge(chan_reg, wb_dat_i, wb_sel_i);
        REG_PACER: pacer_next = merge(pacer_reg, wb_dat_i, wb_sel_i);
        REG_IMASK: begin
          if (wb_sel_i[0]) imask_next = wb_dat_i[IRQ_W-1:0];
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        REG_CTRL: dat_next = ctrl_reg;
        REG_CHAN: dat_next = chan_reg;
        REG_PACER: dat_next = pacer_reg;
        // empty read hands back zero, not a stale sample
        REG_DATA: dat_next = {16'h0000, fif.empty ? 16'h0000 : fif.rdata}; // R10 R12
        REG_STAT: dat_next = stat_word;
        REG_ISTAT: dat_next = {28'h0000000, istat_reg};
        REG_IMASK: dat_next = {28'h0000000, imask_reg};
        default: dat_next = 32'h0000_0000;
      endcase
    end
    // set wins over a clear in the same cycle
    istat_next = (istat_reg & ~w1c) | events; // R13
    irq_next = |(istat_next & imask_next); // R13
    ack_next = req;
    half_next = (fif.count >= HALF_CNT); // R1
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      chan_reg <= CHAN_RST;
      pacer_reg <= PACER_RST;
      imask_reg <= IMASK_RST;
      istat_reg <= '0;
      dat_reg <= '0;
      ack_reg <= 1'b0;
      irq_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      chan_reg <= chan_next;
      pacer_reg <= pacer_next;
      imask_reg <= imask_next;
      istat_reg <= istat_next;
      dat_reg <= dat_next;
      ack_reg <= ack_next;
      irq_reg <= irq_next;
      half_reg <= half_next;
    end
  end

  // pacer
  logic [DIV_W-1:0] div_reg, div_next;
  logic [PACER_W-1:0] pcnt_reg, pcnt_next;
  logic pfire_reg, pfire_next;
  logic tick, pacer_on;

  // reload while not pacing, so a re-enable always starts a full period
  assign pacer_on = ctrl_reg[CTRL_EN] & (trig_sel == TRIG_PACER);
  assign tick = ctrl_reg[CTRL_EXTCLK] ? eclk_rise : (div_reg == DIV_LAST); // R7

  always_comb begin
    div_next = (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1; // R7
    pcnt_next = pcnt_reg;
    pfire_next = 1'b0;
    if (!pacer_on) begin
      pcnt_next = pacer_reg;
    end else if (tick) begin
      if (pcnt_reg == '0) begin
        pcnt_next = pacer_reg; // R6
        pfire_next = 1'b1; // R6
      end else begin
        pcnt_next = pcnt_reg - 1'b1; // R6
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
      pcnt_reg <= '0;
      pfire_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      pcnt_reg <= pcnt_next;
      pfire_reg <= pfire_next;
    end
  end

  // sequencer
  aac_seq_t st_reg, st_next;
  logic [CH_W-1:0] cur_reg, cur_next, ch_max, ch_lo, ch_hi, lo_raw, hi_raw;
  logic start_reg, start_next;
  logic trig;
  logic [1:0] gain_reg, gain_next;
  logic bip_reg, bip_next;

  always_comb begin
    // source code 3 leaves the sequencer with no trigger at all
    case (trig_sel)
      TRIG_SW: trig = sw_trig;
      TRIG_PACER: trig = pfire_reg;
      TRIG_EXT: trig = trig_rise;
      default: trig = 1'b0;
    endcase
    trig = trig & ctrl_reg[CTRL_EN]; // R4
  end

  assign lo_raw = chan_reg[CHAN_LO_LSB +: CH_W];
  assign hi_raw = chan_reg[CHAN_HI_LSB +: CH_W];
  assign ch_max = ctrl_reg[CTRL_DIFF] ? CH_W'(CH_DIFF - 1) : CH_W'(CH_SE - 1); // R9
  assign ch_lo = (lo_raw > ch_max) ? ch_max : lo_raw; // R9
  // a range written backwards collapses to the low channel
  assign ch_hi = (hi_raw > ch_max) ? ch_max : ((hi_raw < ch_lo) ? ch_lo : hi_raw); // R9
  assign busy = (st_reg != SQ_IDLE);

  always_comb begin
    st_next = st_reg;
    cur_next = cur_reg;
    start_next = 1'b0;
    ev_conv = 1'b0;
    ev_scan = 1'b0;
    fif.push = 1'b0;
    fif.wdata = data_s2; // R10
    // front end follows ctrl a cycle late; a change mid-scan applies at once
    gain_next = ctrl_reg[CTRL_GAIN_LSB +: 2]; // R11
    bip_next = ctrl_reg[CTRL_BIP]; // R11
    case (st_reg)
      SQ_IDLE: begin
        // triggers while busy are ignored, the host paces the rate
        if (trig) begin
          cur_next = ch_lo; // R5
          st_next = SQ_START;
        end
      end
      SQ_START: begin
        start_next = 1'b1;
        st_next = SQ_WAIT;
      end
      SQ_WAIT: begin
        if (done_rise) begin
          fif.push = 1'b1; // R1 R10
          ev_conv = 1'b1; // R2
          if (ctrl_reg[CTRL_SCAN] && cur_reg < ch_hi) begin
            cur_next = cur_reg + 1'b1; // R5
            st_next = SQ_START;
          end else begin
            ev_scan = ctrl_reg[CTRL_SCAN]; // R2 R5
            st_next = SQ_IDLE;
          end
        end
      end
      default: st_next = SQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= SQ_IDLE;
      cur_reg <= '0;
      start_reg <= 1'b0;
      gain_reg <= 2'h0;
      bip_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cur_reg <= cur_next;
      start_reg <= start_next;
      gain_reg <= gain_next; // R11
      bip_reg <= bip_next; // R11
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign irq = irq_reg;
  assign adc_start = start_reg;
  assign adc_chan = cur_reg;
  assign adc_gain = gain_reg;
  assign adc_bipolar = bip_reg;
endmodule : aac_top
`default_nettype wire

// file: verification/aac_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aac_top_properties
  import aac_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int HALF = FIFO_HALF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq,
  input wire logic ext_trig,
  input wire logic ext_clk,
  input wire logic adc_done,
  input wire logic [SAMPLE_W-1:0] adc_data,
  input wire logic adc_start,
  input wire logic [CH_W-1:0] adc_chan,
  input wire logic [1:0] adc_gain,
  input wire logic adc_bipolar
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic rd_req = req && !wb_we_i;
  wire logic isr_wr = req && wb_we_i && (wb_adr_i == REG_ISTAT || wb_adr_i == REG_IMASK);
  ack_one_cycle_a: assert property (req |=> wb_ack_o) else $error("ack late");
  ack_no_req_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  start_pulse_a: assert property (adc_start |=> !adc_start [*3]) else $error("start too long");
  chan_settled_a: assert property (adc_start |-> $stable(adc_chan)) else $error("chan moved");
  // a clear or mask write lands at the same edge at which irq follows it
  irq_sticky_a: assert property (irq && !isr_wr && !$past(isr_wr) |=> irq) else $error("irq lost");
  sample_width_a: assert property (wb_ack_o && $past(rd_req && wb_adr_i == REG_DATA)
    |-> wb_dat_o[31:SAMPLE_W] == 16'h0) else $error("upper bits set");
  gain_follow_a: assert property (req && wb_we_i && wb_adr_i == REG_CTRL
    && wb_sel_i == 4'hf |-> ##2 adc_gain == $past(wb_dat_i[CTRL_GAIN_LSB +: 2], 2)
    && adc_bipolar == $past(wb_dat_i[CTRL_BIP], 2)) else $error("gain not driven");
  unmapped_zero_a: assert property (wb_ack_o && $past(rd_req && wb_adr_i > REG_IMASK)
    |-> wb_dat_o == 32'h0) else $error("unmapped data");
endmodule : aac_top_properties
bind aac_top aac_top_properties #(.DEPTH(DEPTH), .HALF(HALF)) u_props (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq(irq), .ext_trig(ext_trig), .ext_clk(ext_clk), .adc_done(adc_done),
  .adc_data(adc_data), .adc_start(adc_start), .adc_chan(adc_chan), .adc_gain(adc_gain),
  .adc_bipolar(adc_bipolar));
`default_nettype wire

// file: verification/aac_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module aac_conv_model (
  input wire logic clk,
  input wire logic adc_start,
  input wire logic [3:0] adc_chan,
  output logic adc_done,
  output logic [15:0] adc_data
);
  int seq = 0;
  logic [3:0] ch;
  logic [3:0] q[$];
  // queued so a start during the done hold is not missed
  always @(posedge clk) if (adc_start === 1'b1) q.push_back(adc_chan);
  initial begin
    adc_done = 1'b0;
    adc_data = 16'hffff;
    forever begin
      @(posedge clk);
      if (q.size() > 0) begin
        ch = q.pop_front();
        repeat ((seq % 2) ? 12 : 3) @(posedge clk);
        adc_data <= {12'(seq), ch};
        @(posedge clk);
        adc_done <= 1'b1;
        repeat (6) @(posedge clk);
        adc_done <= 1'b0;
        // released lines show the inverse, never a stale match
        adc_data <= ~adc_data;
        seq++;
      end
    end
  end
endmodule : aac_conv_model
`default_nettype wire

// file: verification/aac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aac_top_tb;
  import aac_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ext_trig = 0, ext_clk = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, ch;
  logic [31:0] wdat = 32'h0, rd;
  logic b;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, irq, adc_done, adc_start, adc_bipolar;
  wire logic [15:0] adc_data;
  wire logic [3:0] adc_chan;
  wire logic [1:0] adc_gain;
  int n_errors = 0, total_checks = 0, n_conv = 0, cnt = 0, last = 0, gap = 0;
  int seed = 32'h6cfc, k, base;
  aac_top #(.DEPTH(16), .HALF(8)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .ext_trig(ext_trig), .ext_clk(ext_clk),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_gain(adc_gain), .adc_bipolar(adc_bipolar));
  aac_conv_model conv (.clk(clk), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (adc_start === 1'b1) begin
      n_conv <= n_conv + 1;
      gap <= cnt - last;
      last <= cnt;
    end
  end
  function automatic logic [31:0] exp_s(input int n, input logic [3:0] c);
    return {16'h0, 12'(n), c};
  endfunction : exp_s
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) n_errors++;
    // read data is taken at the very edge that shows ack
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic poll(input int bt, input logic v, input int lim);
    int t = 0;
    do begin
      wb(1'b0, REG_STAT, 32'h0);
      t++;
    end while (rd[bt] !== v && t < lim);
    if (t >= lim) n_errors++;
  endtask : poll
  task automatic wait_conv(input int n, input int lim);
    int t = 0;
    while (n_conv < n && t < lim) begin
      @(negedge clk);
      t++;
    end
    if (t >= lim) n_errors++;
  endtask : wait_conv
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, REG_PACER, 32'h0);
    chk("pacer", PACER_RST, rd);
    wb(1'b0, REG_STAT, 32'h0);
    chk("empty", 32'h1, 32'(rd[STAT_EMPTY]));
    wb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, REG_IMASK, 32'hf);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      ch = 4'($random(seed));
      b = 1'($random(seed));
      wb(1'b1, REG_CTRL, 32'h100 | (32'(k) << CTRL_GAIN_LSB) | (32'(b) << CTRL_BIP));
      wb(1'b1, REG_CHAN, 32'(ch));
      base = n_conv;
      wb(1'b1, REG_CMD, 32'h1);
      wait_conv(base + 1, 50);
      chk("chan", 32'(ch), 32'(adc_chan));
      chk("gain", 32'(k), 32'(adc_gain));
      chk("range", 32'(b), 32'(adc_bipolar));
      poll(STAT_EMPTY, 1'b0, 50);
      chk("irq", 32'h1, 32'(irq));
      wb(1'b0, REG_DATA, 32'h0);
      chk("sample", exp_s(base, ch), rd);
      wb(1'b1, REG_ISTAT, 32'hf);
      chk("irq clear", 32'h0, 32'(irq));
    end
    $display("test single done");
    wb(1'b0, REG_DATA, 32'h0);
    chk("empty read", 32'h0, rd);
    wb(1'b0, REG_ISTAT, 32'h0);
    chk("underflow", 32'h1, 32'(rd[IRQ_UNDER]));
    wb(1'b1, REG_ISTAT, 32'hf);
    wb(1'b1, REG_CHAN, 32'h0906);
    wb(1'b1, REG_CTRL, 32'h10c);
    base = n_conv;
    wb(1'b1, REG_CMD, 32'h1);
    wait_conv(base + 2, 200);
    poll(STAT_BUSY, 1'b0, 50);
    chk("scan count", 32'h2, 32'(rd[9:0]));
    wb(1'b0, REG_ISTAT, 32'h0);
    chk("scan done", 32'h1, 32'(rd[IRQ_SCAN]));
    for (k = 0; k < 2; k++) begin
      wb(1'b0, REG_DATA, 32'h0);
      chk("scan sample", exp_s(base + k, 4'(6 + k)), rd);
    end
    $display("test scan done");
    wb(1'b1, REG_ISTAT, 32'hf);
    wb(1'b1, REG_PACER, 32'd99);
    base = n_conv;
    wb(1'b1, REG_CTRL, 32'h101);
    wait_conv(base + 2, 1200);
    chk("pacer period", 32'((99 + 1) * PACER_DIV), 32'(gap));
    poll(STAT_FULL, 1'b1, 4000);
    wb(1'b0, REG_ISTAT, 32'h0);
    chk("half", 32'h1, 32'(rd[IRQ_HALF]));
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (100) @(posedge clk);
    for (k = 0; k < 16; k++) begin
      wb(1'b0, REG_DATA, 32'h0);
      chk("fifo order", exp_s(base + k, 4'h6), rd);
    end
    $display("test fifo done");
    wb(1'b1, REG_PACER, 32'h1);
    base = n_conv;
    wb(1'b1, REG_CTRL, 32'h181);
    repeat (8) begin
      ext_clk <= ~ext_clk;
      repeat (30 + 3'($random(seed))) @(posedge clk);
    end
    chk("ext clock", 32'(base + 2), 32'(n_conv));
    base = n_conv;
    wb(1'b1, REG_CTRL, 32'h102);
    repeat (3) begin
      ext_trig <= 1'b1;
      repeat (3) @(posedge clk);
      ext_trig <= 1'b0;
      repeat (40 + 3'($random(seed))) @(posedge clk);
    end
    chk("ext trigger", 32'(base + 3), 32'(n_conv));
    wb(1'b0, REG_STAT, 32'h0);
    chk("ext samples", 32'h5, 32'(rd[9:0]));
    wb(1'b1, REG_CMD, 32'h2);
    wb(1'b0, REG_STAT, 32'h0);
    chk("flush", 32'h1, 32'(rd[STAT_EMPTY]));
    $display("test triggers done");
    print_verdict();
  end
endmodule : aac_top_tb
`default_nettype wire
